// ### include/art_pkg.sv
// Shared constants, register map and carrier types of the auto-reload timer with capture.
package art_pkg;

    // Bus geometry.
    localparam int unsigned AXI_ADDR_W = 6;
    localparam int unsigned AXI_DATA_W = 32;

    // Default divide ratio of the slow count clock derived from the system clock.
    localparam int unsigned SYS_DIV = 12;

    // Byte addresses of the registers.
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_CLKSEL = 6'h04;
    localparam logic [5:0] OFS_CNT_LO = 6'h08;
    localparam logic [5:0] OFS_CNT_HI = 6'h0c;
    localparam logic [5:0] OFS_RLD_LO = 6'h10;
    localparam logic [5:0] OFS_RLD_HI = 6'h14;
    localparam logic [5:0] OFS_TMR_IE = 6'h18;
    localparam logic [5:0] OFS_EV_STATUS = 6'h1c;
    localparam logic [5:0] OFS_EV_CLEAR = 6'h20;
    localparam logic [5:0] OFS_EV_ENABLE = 6'h24;

    // Reset values and writable-bit masks.
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'hfd;
    localparam logic [7:0] CLKSEL_RST = 8'h00;
    localparam logic [7:0] CLKSEL_WMASK = 8'h30;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [7:0] BYTE_ALL_ONES = 8'hff;
    localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [2:0] EV_RST = 3'h0;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timer control register, bit 7 down to bit 0.
    typedef struct packed {
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_byte_irq_enable;
        logic capture_mode_enable;
        logic split_mode_select;
        logic run_control;
        logic reserved_b1;
        logic external_clock_select;
    } art_ctrl_t;

    // Clock control register, bit 7 down to bit 0.
    typedef struct packed {
        logic [1:0] reserved_hi;
        logic high_half_clock_select;
        logic low_half_clock_select;
        logic [3:0] reserved_lo;
    } art_clksel_t;

    // Event bits, shared by status, clear and enable registers.
    typedef struct packed {
        logic capture;
        logic low_ovf;
        logic high_ovf;
    } art_ev_t;

    // Count-clock strobes from the tick generator.
    typedef struct packed {
        logic div_tick;
        logic ext_fall;
    } art_tick_t;

    // Register selected by a bus address.
    typedef enum logic [3:0] {
        SEL_CTRL,
        SEL_CLKSEL,
        SEL_CNT_LO,
        SEL_CNT_HI,
        SEL_RLD_LO,
        SEL_RLD_HI,
        SEL_TMR_IE,
        SEL_EV_STATUS,
        SEL_EV_CLEAR,
        SEL_EV_ENABLE,
        SEL_NONE
    } art_sel_t;

endpackage

// ### core/art_tick_gen.sv
// Prescaler and external clock synchroniser that produce the count-clock strobes.
`timescale 1ns/100ps
module art_tick_gen #(
    parameter int unsigned PRESCALE = art_pkg::SYS_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ext_osc_div8,
    output art_pkg::art_tick_t tick
);

    localparam int unsigned DIV_W = $clog2(PRESCALE);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PRESCALE - 1);
    localparam logic [DIV_W-1:0] DIV_ZERO = '0;

    logic [DIV_W-1:0] div_cnt_q;
    logic div_tick_q;
    logic [2:0] sync_q;
    logic level_q;
    logic fall_q;

    // Free-running prescaler; the strobe lasts one cycle out of every PRESCALE.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_q <= DIV_ZERO;
            div_tick_q <= 1'b0;
        end else if (div_cnt_q == DIV_LAST) begin
            div_cnt_q <= DIV_ZERO;
            div_tick_q <= 1'b1;
        end else begin
            div_cnt_q <= div_cnt_q + DIV_W'(1);
            div_tick_q <= 1'b0;
        end
    end

    // Three-stage synchroniser; stage zero feeds only stage one.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], ext_osc_div8};
        end
    end

    // A level counts once stages one and two agree, which filters a single metastable sample.
    // The level starts low so a clock already high at reset yields no false edge.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            fall_q <= 1'b0;
            if (sync_q[1] == sync_q[2]) begin
                level_q <= sync_q[2];
                fall_q <= level_q && !sync_q[2];
            end
        end
    end

    assign tick.div_tick = div_tick_q;
    assign tick.ext_fall = fall_q;

endmodule

// ### core/art_timer.sv
// Auto-reload timer with split mode, external clock capture and an AXI4-Lite register slave.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
module art_timer #(
    parameter int unsigned PRESCALE = art_pkg::SYS_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ext_osc_div8,
    input wire logic [art_pkg::AXI_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [art_pkg::AXI_DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [art_pkg::AXI_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [art_pkg::AXI_DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq
);

    // Maps a bus address onto a register; used by both the write and the read path.
    function automatic art_pkg::art_sel_t reg_decode(input logic [art_pkg::AXI_ADDR_W-1:0] a);
        case (a)
            art_pkg::OFS_CTRL: reg_decode = art_pkg::SEL_CTRL;
            art_pkg::OFS_CLKSEL: reg_decode = art_pkg::SEL_CLKSEL;
            art_pkg::OFS_CNT_LO: reg_decode = art_pkg::SEL_CNT_LO;
            art_pkg::OFS_CNT_HI: reg_decode = art_pkg::SEL_CNT_HI;
            art_pkg::OFS_RLD_LO: reg_decode = art_pkg::SEL_RLD_LO;
            art_pkg::OFS_RLD_HI: reg_decode = art_pkg::SEL_RLD_HI;
            art_pkg::OFS_TMR_IE: reg_decode = art_pkg::SEL_TMR_IE;
            art_pkg::OFS_EV_STATUS: reg_decode = art_pkg::SEL_EV_STATUS;
            art_pkg::OFS_EV_CLEAR: reg_decode = art_pkg::SEL_EV_CLEAR;
            art_pkg::OFS_EV_ENABLE: reg_decode = art_pkg::SEL_EV_ENABLE;
            default: reg_decode = art_pkg::SEL_NONE;
        endcase
    endfunction

    art_pkg::art_tick_t tick;
    art_pkg::art_ctrl_t ctrl_q;
    art_pkg::art_clksel_t clksel_q;
    art_pkg::art_ev_t ev_status_q;
    art_pkg::art_ev_t ev_enable_q;
    art_pkg::art_ev_t ev_now;
    art_pkg::art_sel_t wr_sel;
    art_pkg::art_sel_t rd_sel;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [15:0] reload_q;
    logic tmr_ie_q;
    logic irq_q;
    logic aw_held_q;
    logic [art_pkg::AXI_ADDR_W-1:0] awaddr_q;
    logic w_held_q;
    logic [7:0] wbyte_q;
    logic wstrb0_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [art_pkg::AXI_DATA_W-1:0] rdata_q;
    logic [7:0] rd_val;
    logic wr_fire;
    logic wr_byte;
    logic lo_tick;
    logic hi_tick;
    logic cap_ev;
    logic lo_roll;
    logic hi_roll;

    art_tick_gen #(
        .PRESCALE(PRESCALE)
    ) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .ext_osc_div8(ext_osc_div8),
        .tick(tick)
    );

    // Write side: address and data are taken independently, in either order, and held until both are in.
    assign awready = !aw_held_q && !bvalid_q;
    assign wready = !w_held_q && !bvalid_q;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign wr_sel = reg_decode(awaddr_q);
    assign wr_byte = wr_fire && wstrb0_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awaddr_q <= '0;
        end else if (awvalid && awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    // Only byte lane zero carries register data; a write with that lane off changes nothing.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wbyte_q <= art_pkg::BYTE_RST;
            wstrb0_q <= 1'b0;
        end else if (wvalid && wready) begin
            w_held_q <= 1'b1;
            wbyte_q <= wdata[7:0];
            wstrb0_q <= wstrb[0];
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    // Write response; an unmapped address is answered with a slave error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= art_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wr_sel == art_pkg::SEL_NONE) ? art_pkg::RESP_SLVERR : art_pkg::RESP_OKAY;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    // Count strobes per half. Capture mode takes the external edge away from the low half,
    // because that edge now marks the capture instant instead of advancing the count.
    always_comb begin
        if (clksel_q.low_half_clock_select) begin
            lo_tick = 1'b1;
        end else if (ctrl_q.external_clock_select && !ctrl_q.capture_mode_enable) begin
            lo_tick = tick.ext_fall;
        end else begin
            lo_tick = tick.div_tick;
        end
        if (clksel_q.high_half_clock_select) begin
            hi_tick = 1'b1;
        end else if (ctrl_q.external_clock_select) begin
            hi_tick = tick.ext_fall;
        end else begin
            hi_tick = tick.div_tick;
        end
    end

    assign cap_ev = ctrl_q.capture_mode_enable && tick.ext_fall;

    // Next count: 16-bit or split counting, then software writes, which win over counting.
    always_comb begin
        cnt_d = cnt_q;
        lo_roll = 1'b0;
        hi_roll = 1'b0;
        if (!ctrl_q.split_mode_select) begin
            if (ctrl_q.run_control && lo_tick) begin
                lo_roll = (cnt_q[7:0] == art_pkg::BYTE_ALL_ONES);
                if (cnt_q == art_pkg::CNT_ALL_ONES) begin
                    cnt_d = reload_q;
                    hi_roll = 1'b1;
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                end
            end
        end else begin
            if (lo_tick) begin
                lo_roll = (cnt_q[7:0] == art_pkg::BYTE_ALL_ONES);
                cnt_d[7:0] = lo_roll ? reload_q[7:0] : cnt_q[7:0] + 8'h01;
            end
            if (ctrl_q.run_control && hi_tick) begin
                hi_roll = (cnt_q[15:8] == art_pkg::BYTE_ALL_ONES);
                cnt_d[15:8] = hi_roll ? reload_q[15:8] : cnt_q[15:8] + 8'h01;
            end
        end
        if (wr_byte && wr_sel == art_pkg::SEL_CNT_LO) begin
            cnt_d[7:0] = wbyte_q;
        end
        if (wr_byte && wr_sel == art_pkg::SEL_CNT_HI) begin
            cnt_d[15:8] = wbyte_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= art_pkg::WORD_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Reload registers; a capture in the same cycle as a software write takes precedence.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reload_q <= art_pkg::WORD_RST;
        end else if (cap_ev) begin
            reload_q <= cnt_q;
        end else begin
            if (wr_byte && wr_sel == art_pkg::SEL_RLD_LO) begin
                reload_q[7:0] <= wbyte_q;
            end
            if (wr_byte && wr_sel == art_pkg::SEL_RLD_HI) begin
                reload_q[15:8] <= wbyte_q;
            end
        end
    end

    // Control register. Overflow flags are set by hardware or by a software write of one; a set in the
    // same cycle as a software write of zero wins so that no overflow is lost.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= art_pkg::CTRL_RST;
        end else begin
            if (wr_byte && wr_sel == art_pkg::SEL_CTRL) begin
                ctrl_q <= wbyte_q & art_pkg::CTRL_WMASK;
            end
            if (hi_roll || cap_ev) begin
                ctrl_q.high_overflow_flag <= 1'b1;
            end
            if (lo_roll) begin
                ctrl_q.low_overflow_flag <= 1'b1;
            end
        end
    end

    // Clock select and timer interrupt enable registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clksel_q <= art_pkg::CLKSEL_RST;
            tmr_ie_q <= 1'b0;
        end else begin
            if (wr_byte && wr_sel == art_pkg::SEL_CLKSEL) begin
                clksel_q <= wbyte_q & art_pkg::CLKSEL_WMASK;
            end
            if (wr_byte && wr_sel == art_pkg::SEL_TMR_IE) begin
                tmr_ie_q <= wbyte_q[0];
            end
        end
    end

    // Sticky event status: writing ones to the clear register drops bits, new events win.
    assign ev_now.high_ovf = hi_roll;
    assign ev_now.low_ovf = lo_roll;
    assign ev_now.capture = cap_ev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_status_q <= art_pkg::EV_RST;
            ev_enable_q <= art_pkg::EV_RST;
        end else begin
            if (wr_byte && wr_sel == art_pkg::SEL_EV_CLEAR) begin
                ev_status_q <= (ev_status_q & ~wbyte_q[2:0]) | ev_now;
            end else begin
                ev_status_q <= ev_status_q | ev_now;
            end
            if (wr_byte && wr_sel == art_pkg::SEL_EV_ENABLE) begin
                ev_enable_q <= wbyte_q[2:0];
            end
        end
    end

    // One level interrupt: the flag-based timer request or any enabled sticky event.
    // The low flag only requests when the low-byte enable is set, in either mode.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (tmr_ie_q && (ctrl_q.high_overflow_flag
                || (ctrl_q.low_byte_irq_enable && ctrl_q.low_overflow_flag)))
                || ((ev_status_q & ev_enable_q) != art_pkg::EV_RST);
        end
    end

    assign irq = irq_q;

    // Read side: one read at a time, data registered on acceptance.
    assign arready = !rvalid_q;
    assign rd_sel = reg_decode(araddr);

    always_comb begin
        case (rd_sel)
            art_pkg::SEL_CTRL: rd_val = ctrl_q;
            art_pkg::SEL_CLKSEL: rd_val = clksel_q;
            art_pkg::SEL_CNT_LO: rd_val = cnt_q[7:0];
            art_pkg::SEL_CNT_HI: rd_val = cnt_q[15:8];
            art_pkg::SEL_RLD_LO: rd_val = reload_q[7:0];
            art_pkg::SEL_RLD_HI: rd_val = reload_q[15:8];
            art_pkg::SEL_TMR_IE: rd_val = {7'h00, tmr_ie_q};
            art_pkg::SEL_EV_STATUS: rd_val = {5'h00, ev_status_q};
            art_pkg::SEL_EV_ENABLE: rd_val = {5'h00, ev_enable_q};
            default: rd_val = art_pkg::BYTE_RST;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= art_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= {24'h000000, rd_val};
            rresp_q <= (rd_sel == art_pkg::SEL_NONE) ? art_pkg::RESP_SLVERR : art_pkg::RESP_OKAY;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

endmodule

// ### tb/art_timer_props.sv
// Concurrent checks of the register bus handshake and interrupt line of the timer.
`timescale 1ns/100ps
module art_timer_props #(
    parameter int unsigned PRESCALE = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [5:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic irq
);
    // All checks live in the single system clock domain.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read response dropped early");
    property p_ar_block; rvalid |-> !arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read address taken during response");
    property p_rd_lat; arvalid && arready |=> rvalid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_wr_lat; awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid; endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write answer not on the second edge");
    property p_rd_upper; rvalid |-> rdata[31:8] == 24'h0; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits not zero");
    property p_rd_err; arvalid && arready && araddr > 6'h24 |=> rresp == 2'h2 && rdata == 32'h0; endproperty
    a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
    property p_wr_err; awvalid && awready && wvalid && wready && awaddr > 6'h24 |-> ##2 bresp == 2'h2; endproperty
    a_wr_err: assert property (p_wr_err) else $error("unmapped write not refused");
    property p_b_cause; $rose(bvalid) |-> $past(awvalid && awready, 2); endproperty
    a_b_cause: assert property (p_b_cause) else $error("write answer without request");
    // Flags are sticky, so the line may only drop after software wrote something.
    property p_irq_sticky; $fell(irq) |-> $past(wvalid && wready, 2) || $past(wvalid && wready, 3); endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("interrupt dropped without write");
endmodule

bind art_timer art_timer_props #(.PRESCALE(PRESCALE)) i_art_timer_props (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .irq);

// ### tb/art_timer_bench.sv
// Self-checking testbench of the auto-reload timer with capture.
`timescale 1ns/100ps
module art_timer_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ext_osc_div8 = 1'b1;
    logic [5:0] awaddr = 6'h0, araddr = 6'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    int errors = 0, n_tests = 0;
    logic [31:0] rng = 32'hc2c23e0d;
    logic ext_run = 1'b0;
    logic [2:0] ext_cnt = 3'h0;
    logic [7:0] v, a, b, rl, rh;

    // Clock at 40 MHz.
    always #12.5 aclk = ~aclk;

    art_timer #(.PRESCALE(12)) i_art_timer (.aclk, .aresetn, .ext_osc_div8, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .irq);

    // External clock already divided, one fall every 16 cycles while enabled.
    always @(posedge aclk) begin
        if (ext_run) begin
            ext_cnt <= ext_cnt + 3'h1;
            if (ext_cnt == 3'h7) ext_osc_div8 <= ~ext_osc_div8;
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // Expected increments over a span, allowing one tick of phase slack.
    function automatic logic near(input logic [7:0] d, input int cycles, input int per);
        return d >= cycles / per && d <= cycles / per + 1;
    endfunction

    task automatic tally_and_finish;
        if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // A wait that runs out is a mismatch and ends the run.
    task automatic hang(input int k);
        if (k > 50) begin
            errors++;
            tally_and_finish;
        end
    endtask

    // Bus write; address and data are offered together and released as each is taken.
    task automatic wr(input logic [5:0] ad, input logic [7:0] d, input logic [1:0] er = 2'h0);
        int k;
        logic ta, tw;
        @(posedge aclk);
        awaddr <= ad;
        wdata <= {24'h0, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        ta = 1'b0;
        tw = 1'b0;
        k = 0;
        while (!(ta && tw)) begin
            @(posedge aclk);
            if (!ta && awready) begin
                ta = 1'b1;
                awvalid <= 1'b0;
            end
            if (!tw && wready) begin
                tw = 1'b1;
                wvalid <= 1'b0;
            end
            k++;
            hang(k);
        end
        do begin
            @(posedge aclk);
            k++;
            hang(k);
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", 32'(bresp), 32'(er));
    endtask

    task automatic rd(input logic [5:0] ad, output logic [7:0] d, input logic [1:0] er = 2'h0);
        int k;
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
            hang(k);
        end while (!arready);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            k++;
            hang(k);
        end while (!rvalid);
        d = rdata[7:0];
        rready <= 1'b0;
        chk("rresp", 32'(rresp), 32'(er));
    endtask

    task automatic rc(input string nm, input logic [5:0] ad, input logic [7:0] e);
        logic [7:0] d;
        rd(ad, d);
        chk(nm, 32'(d), 32'(e));
    endtask

    // Main sequence: reset, register map, then each counting mode.
    initial begin
        tick(6);
        aresetn <= 1'b1;
        for (int i = 0; i < 10; i++) rc("reset", 6'(i * 4), 8'h00);
        rd(6'h28, v, 2'h2);
        wr(6'h3c, 8'h01, 2'h2);
        rng = xs(rng);
        wr(art_pkg::OFS_CLKSEL, rng[7:0]);
        rc("clksel", art_pkg::OFS_CLKSEL, rng[7:0] & art_pkg::CLKSEL_WMASK);
        v = (rng[15:8] & 8'he1) | 8'h02;
        wr(art_pkg::OFS_CTRL, v);
        rc("ctrl", art_pkg::OFS_CTRL, v & art_pkg::CTRL_WMASK);
        wr(art_pkg::OFS_CTRL, 8'h00);
        // Full 16-bit rollover with random reload; a small low reload keeps the high byte still.
        rl = {2'b00, rng[21:16]};
        rh = rng[31:24];
        wr(art_pkg::OFS_CLKSEL, 8'h10);
        wr(art_pkg::OFS_CNT_LO, 8'hfe);
        wr(art_pkg::OFS_CNT_HI, 8'hff);
        wr(art_pkg::OFS_RLD_LO, rl);
        wr(art_pkg::OFS_RLD_HI, rh);
        wr(art_pkg::OFS_TMR_IE, 8'h01);
        wr(art_pkg::OFS_CTRL, 8'h04);
        rc("ovf16", art_pkg::OFS_CTRL, 8'hc4);
        wr(art_pkg::OFS_CTRL, 8'hc0);
        rc("sticky", art_pkg::OFS_CTRL, 8'hc0);
        rc("reload_hi", art_pkg::OFS_CNT_HI, rh);
        rd(art_pkg::OFS_CNT_LO, v);
        chk("reload_lo", {31'h0, 8'(v - rl) < 8'h40}, 32'h1);
        chk("irq16", {31'h0, irq}, 32'h1);
        wr(art_pkg::OFS_CTRL, 8'h00);
        tick(4);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        // Low byte roll only; its interrupt needs the low-byte enable.
        wr(art_pkg::OFS_CNT_LO, 8'hfe);
        wr(art_pkg::OFS_CNT_HI, 8'h12);
        wr(art_pkg::OFS_CTRL, 8'h04);
        rc("low_only", art_pkg::OFS_CTRL, 8'h44);
        wr(art_pkg::OFS_CTRL, 8'h40);
        tick(4);
        chk("irq_lo_off", {31'h0, irq}, 32'h0);
        wr(art_pkg::OFS_CTRL, 8'h60);
        tick(4);
        chk("irq_lo_on", {31'h0, irq}, 32'h1);
        rc("carry", art_pkg::OFS_CNT_HI, 8'h13);
        // Split mode: low byte runs without run control, high byte held.
        wr(art_pkg::OFS_CTRL, 8'h00);
        rng = xs(rng);
        rl = rng[7:0] | 8'hf0;
        wr(art_pkg::OFS_CNT_LO, 8'hfe);
        wr(art_pkg::OFS_CNT_HI, 8'h5a);
        wr(art_pkg::OFS_RLD_LO, rl);
        wr(art_pkg::OFS_CTRL, 8'h08);
        tick(40);
        rc("split_lo", art_pkg::OFS_CTRL, 8'h48);
        rc("hold_hi", art_pkg::OFS_CNT_HI, 8'h5a);
        rd(art_pkg::OFS_CNT_LO, v);
        chk("lo_range", {31'h0, v >= rl}, 32'h1);
        chk("irq_split_lo", {31'h0, irq}, 32'h0);
        wr(art_pkg::OFS_CNT_HI, 8'hff);
        wr(art_pkg::OFS_CLKSEL, 8'h30);
        wr(art_pkg::OFS_CTRL, 8'h0c);
        rd(art_pkg::OFS_CTRL, v);
        chk("split_hi", {31'h0, v[7]}, 32'h1);
        tick(3);
        chk("irq_split_hi", {31'h0, irq}, 32'h1);
        // Low half clock sources: system clock over 12, then external over 8.
        wr(art_pkg::OFS_CTRL, 8'h00);
        wr(art_pkg::OFS_CLKSEL, 8'h00);
        wr(art_pkg::OFS_CNT_LO, 8'h00);
        ext_run <= 1'b1;
        // The third pass is capture mode with the external select set: the count must stay on the divided clock.
        for (int m = 0; m < 3; m++) begin
            wr(art_pkg::OFS_CTRL, (m == 2) ? 8'h15 : {7'h04, m[0]});
            rd(art_pkg::OFS_CNT_LO, a);
            tick(m == 1 ? 160 : 120);
            rd(art_pkg::OFS_CNT_LO, b);
            chk("rate", {31'h0, near(b - a, m == 1 ? 160 : 120, m == 1 ? 16 : art_pkg::SYS_DIV)}, 32'h1);
        end
        // Capture every external fall while counting each system clock.
        wr(art_pkg::OFS_TMR_IE, 8'h00);
        wr(art_pkg::OFS_CTRL, 8'h00);
        wr(art_pkg::OFS_CLKSEL, 8'h10);
        wr(art_pkg::OFS_CNT_LO, 8'h00);
        wr(art_pkg::OFS_CNT_HI, 8'h00);
        wr(art_pkg::OFS_CTRL, 8'h14);
        tick(40);
        rd(art_pkg::OFS_RLD_LO, a);
        tick(37);
        rd(art_pkg::OFS_RLD_LO, b);
        chk("cap_step", {28'h0, 4'(b - a)}, 32'h0);
        // Two or three captures fall between the reads, each sixteen counts after the last.
        chk("cap_gap", {31'h0, 8'(b - a) == 8'h20 || 8'(b - a) == 8'h30}, 32'h1);
        rd(art_pkg::OFS_CTRL, v);
        chk("cap_flag", {31'h0, v[7]}, 32'h1);
        rd(art_pkg::OFS_EV_STATUS, v);
        chk("cap_ev", 32'(v & 8'h05), 32'h5);
        wr(art_pkg::OFS_EV_ENABLE, 8'h04);
        tick(4);
        chk("irq_ev", {31'h0, irq}, 32'h1);
        wr(art_pkg::OFS_CTRL, 8'h00);
        ext_run <= 1'b0;
        tick(40);
        wr(art_pkg::OFS_EV_CLEAR, 8'h07);
        tick(4);
        chk("irq_ev_clr", {31'h0, irq}, 32'h0);
        wr(art_pkg::OFS_EV_STATUS, 8'h07);
        rc("ev_status", art_pkg::OFS_EV_STATUS, 8'h00);
        tally_and_finish;
    end
endmodule
